// [dtf_pkg.sv]
package dtf_pkg;

	////////////////////////////////////////////////////////////////////////
	// instruction classes covered by the timing and flag decoder
	typedef enum logic [5:0] {
		OP_NOP,
		OP_ASR_ONE,
		OP_ASR_MULTI,
		OP_BRANCH_COND,
		OP_BIT_SKIP_CLEAR,
		OP_BIT_SKIP_SET,
		OP_CMP_SKIP_EQUAL,
		OP_CMP_SKIP_GREATER,
		OP_CMP_SKIP_LESS,
		OP_CMP_SKIP_UNEQUAL,
		OP_TEST_SET_C,
		OP_TEST_SET_Z,
		OP_HOLDOFF,
		OP_DIVIDE,
		OP_FRAC_DIVIDE,
		OP_HW_LOOP,
		OP_REPEAT,
		OP_SQ_DIST,
		OP_SQ_DIST_ACC,
		OP_FIND_BIT,
		OP_MULT_ACC,
		OP_NEG_MULT_ACC,
		OP_DOUBLE_MOVE,
		OP_MOVE_NZ,
		OP_MOVE_PLAIN,
		OP_INT_MULTIPLY,
		OP_DOUBLE_STACK,
		OP_PUSH_SHADOW,
		OP_POP_SHADOW,
		OP_POWER_SAVE,
		OP_WATCHDOG_CLEAR,
		OP_RETURN,
		OP_DECIMAL_ADJUST,
		OP_CMP_BORROW
	} dtf_op_e;

	////////////////////////////////////////////////////////////////////////
	// positions in the flag update mask
	localparam int FLAG_W      = 13;
	localparam int FLG_C       = 0;
	localparam int FLG_DC      = 1;
	localparam int FLG_N       = 2;
	localparam int FLG_OV      = 3;
	localparam int FLG_Z       = 4;
	localparam int FLG_OA      = 5;
	localparam int FLG_OB      = 6;
	localparam int FLG_SA      = 7;
	localparam int FLG_SB      = 8;
	localparam int FLG_OAB     = 9;
	localparam int FLG_SAB     = 10;
	localparam int FLG_WATCHDOG_TIMEOUT_FLAG    = 11;
	localparam int FLG_SLEEP   = 12;
	localparam logic [FLAG_W-1:0] FLAGS_ALL = 13'h07ff;

	////////////////////////////////////////////////////////////////////////
	// timing counts in instruction cycles, and word counts
	localparam logic [4:0] CYC_ONE      = 5'h01;
	localparam logic [4:0] CYC_TWO      = 5'h02;
	localparam logic [4:0] CYC_THREE    = 5'h03;
	localparam logic [4:0] CYC_DIVIDE   = 5'h12;
	localparam logic [1:0] WORDS_ONE    = 2'h1;
	localparam logic [1:0] WORDS_TWO    = 2'h2;
	localparam int         LIT_W        = 14;

	////////////////////////////////////////////////////////////////////////
	// sequencer and holdoff state
	typedef struct packed {
		logic              active;
		logic [4:0]        remain;
		logic              ready;
		logic              done;
		logic [4:0]        cycles;
		logic [1:0]        words;
		logic [FLAG_W-1:0] flagMask;
		logic              accAccumulate;
		logic              accNegate;
		logic [LIT_W:0]    iterCount;
		logic              iterLoad;
		logic              sleepReq;
		logic              idleReq;
	} dtf_seq_s;

	typedef struct packed {
		logic [LIT_W-1:0] left;
		logic             active;
	} dtf_hold_s;

endpackage

// [dtf_hold_if.sv]
interface dtf_hold_if;
	import dtf_pkg::*;
	logic             load;
	logic [LIT_W-1:0] count;
	logic             active;
	modport seq  (output load, output count, input active);
	modport hold (input load, input count, output active);
endinterface

// [dtf_holdoff.sv]
module dtf_holdoff
	import dtf_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	dtf_hold_if.hold  hold
);

	dtf_hold_s st;
	dtf_hold_s next_st;

	////////////////////////////////////////////////////////////////////////
	// count down instruction cycles while interrupts are held off
	always_comb begin
		next_st = st;
		if (hold.load) begin
			next_st.left   = hold.count;
			next_st.active = (hold.count != '0);
		end else if (st.left != '0) begin
			next_st.left   = st.left - 1'b1;
			next_st.active = (st.left != {{(LIT_W-1){1'b0}}, 1'b1});
		end else begin
			next_st.active = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign hold.active = st.active;

endmodule

// [dtf_timing_flags.sv]
module dtf_timing_flags
	import dtf_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              issueValid,
	input  wire dtf_op_e           issueOp,
	input  wire logic              condTrue,
	input  wire logic              nextTwoWord,
	input  wire logic              retShort,
	input  wire logic [15:0]       operandA,
	input  wire logic [15:0]       operandB,
	input  wire logic [LIT_W-1:0]  opLiteral,
	output logic                   ready,
	output logic                   done,
	output logic [4:0]             cycles,
	output logic [1:0]             words,
	output logic [FLAG_W-1:0]      flagMask,
	output logic                   accAccumulate,
	output logic                   accNegate,
	output logic [LIT_W:0]         iterCount,
	output logic                   iterLoad,
	output logic                   sleepReq,
	output logic                   idleReq,
	output logic                   intHoldoff
);

	////////////////////////////////////////////////////////////////////////
	// decoding functions

	function automatic logic [FLAG_W-1:0] flagsFor(input dtf_op_e op);
		logic [FLAG_W-1:0] m;
		m = '0;
		case (op)
			OP_ASR_ONE: begin
				m[FLG_C]  = 1'b1;
				m[FLG_N]  = 1'b1;
				m[FLG_OV] = 1'b1;
				m[FLG_Z]  = 1'b1;
			end
			OP_ASR_MULTI, OP_MOVE_NZ: begin
				m[FLG_N] = 1'b1;
				m[FLG_Z] = 1'b1;
			end
			OP_TEST_SET_C, OP_FIND_BIT,
			OP_DECIMAL_ADJUST: m[FLG_C] = 1'b1;
			OP_TEST_SET_Z: m[FLG_Z] = 1'b1;
			OP_DIVIDE, OP_FRAC_DIVIDE, OP_CMP_BORROW: begin
				m[FLG_DC] = (op == OP_CMP_BORROW);
				m[FLG_N]  = 1'b1;
				m[FLG_Z]  = 1'b1;
				m[FLG_C]  = 1'b1;
				m[FLG_OV] = 1'b1;
			end
			OP_SQ_DIST, OP_SQ_DIST_ACC, OP_MULT_ACC: begin
				m[FLG_OA]  = 1'b1;
				m[FLG_OB]  = 1'b1;
				m[FLG_OAB] = 1'b1;
				m[FLG_SA]  = 1'b1;
				m[FLG_SB]  = 1'b1;
				m[FLG_SAB] = 1'b1;
			end
			OP_POP_SHADOW: m = FLAGS_ALL;
			OP_POWER_SAVE, OP_WATCHDOG_CLEAR: begin
				m[FLG_WATCHDOG_TIMEOUT_FLAG]  = 1'b1;
				m[FLG_SLEEP] = 1'b1;
			end
			default: m = '0;
		endcase
		return m;
	endfunction

	function automatic logic [4:0] cyclesFor(
		input dtf_op_e op,
		input logic    skip,
		input logic    twoWord,
		input logic    shortRet
	);
		logic [4:0] c;
		c = CYC_ONE;
		case (op)
			OP_BRANCH_COND: c = skip ? CYC_TWO : CYC_ONE;
			OP_BIT_SKIP_CLEAR, OP_BIT_SKIP_SET,
			OP_CMP_SKIP_EQUAL, OP_CMP_SKIP_GREATER,
			OP_CMP_SKIP_LESS, OP_CMP_SKIP_UNEQUAL:
				c = !skip ? CYC_ONE : (twoWord ? CYC_THREE : CYC_TWO);
			OP_DIVIDE, OP_FRAC_DIVIDE: c = CYC_DIVIDE;
			OP_HW_LOOP, OP_DOUBLE_MOVE, OP_DOUBLE_STACK: c = CYC_TWO;
			OP_RETURN: c = shortRet ? CYC_TWO : CYC_THREE;
			default: c = CYC_ONE;
		endcase
		return c;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// skip and branch condition

	logic skipCond;
	logic accept;

	always_comb begin
		case (issueOp)
			OP_BIT_SKIP_CLEAR:   skipCond = !condTrue;
			OP_BIT_SKIP_SET:     skipCond = condTrue;
			OP_CMP_SKIP_EQUAL:   skipCond = (operandA == operandB);
			OP_CMP_SKIP_GREATER: skipCond = ($signed(operandA) >
			                                 $signed(operandB));
			OP_CMP_SKIP_LESS:    skipCond = ($signed(operandA) <
			                                 $signed(operandB));
			OP_CMP_SKIP_UNEQUAL: skipCond = (operandA != operandB);
			default:             skipCond = condTrue;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer

	dtf_seq_s st;
	dtf_seq_s next_st;
	logic [4:0] total;

	assign accept = issueValid && (!st.active || st.remain == '0);
	assign total  = cyclesFor(issueOp, skipCond, nextTwoWord, retShort);

	always_comb begin
		next_st          = st;
		next_st.done     = 1'b0;
		next_st.iterLoad = 1'b0;
		next_st.sleepReq = 1'b0;
		next_st.idleReq  = 1'b0;
		if (st.active && st.remain == '0) begin
			next_st.active = 1'b0;
			next_st.done   = 1'b1;
		end else if (st.active) begin
			next_st.remain = st.remain - 1'b1;
		end
		if (accept) begin
			next_st.active        = 1'b1;
			next_st.remain        = total - 1'b1;
			next_st.cycles        = total;
			next_st.flagMask      = flagsFor(issueOp);
			next_st.words = (issueOp == OP_HW_LOOP) ? WORDS_TWO : WORDS_ONE;
			next_st.accAccumulate = (issueOp == OP_SQ_DIST_ACC) ||
			                        (issueOp == OP_MULT_ACC);
			next_st.accNegate     = (issueOp == OP_NEG_MULT_ACC);
			if (issueOp == OP_HW_LOOP || issueOp == OP_REPEAT) begin
				next_st.iterCount = {1'b0, opLiteral} + 1'b1;
				next_st.iterLoad  = 1'b1;
			end
			if (issueOp == OP_POWER_SAVE) begin
				next_st.sleepReq = !opLiteral[0];
				next_st.idleReq  = opLiteral[0];
			end
		end
		next_st.ready = !next_st.active || next_st.remain == '0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st       <= '0;
			st.ready <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt holdoff

	dtf_hold_if holdBus ();

	assign holdBus.load  = accept && issueOp == OP_HOLDOFF;
	assign holdBus.count = opLiteral;

	dtf_holdoff u_holdoff (
		.clk   (clk),
		.rst_n (rst_n),
		.hold  (holdBus)
	);

	assign ready         = st.ready;
	assign done          = st.done;
	assign cycles        = st.cycles;
	assign words         = st.words;
	assign flagMask      = st.flagMask;
	assign accAccumulate = st.accAccumulate;
	assign accNegate     = st.accNegate;
	assign iterCount     = st.iterCount;
	assign iterLoad      = st.iterLoad;
	assign sleepReq      = st.sleepReq;
	assign idleReq       = st.idleReq;
	assign intHoldoff    = holdBus.active;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_two_cycle;
		!done ##1 done;
	endsequence

	sequence s_three_cycle;
		!done ##1 !done ##1 done;
	endsequence

	property p_shift_one;
		accept && issueOp == OP_ASR_ONE |=> cycles == 5'h01 &&
			flagMask == 13'h001d ##1 done;
	endproperty
	a_shift_one: assert property (p_shift_one)
		else $error("single shift timing or flags wrong");

	property p_branch_taken;
		accept && issueOp == OP_BRANCH_COND && condTrue |=>
			flagMask == '0 && cycles == 5'h02 ##1 s_two_cycle;
	endproperty
	a_branch_taken: assert property (p_branch_taken)
		else $error("taken branch not two cycles");

	property p_skip_long;
		accept && issueOp == OP_BIT_SKIP_SET && condTrue && nextTwoWord
			|=> cycles == 5'h03 ##1 s_three_cycle;
	endproperty
	a_skip_long: assert property (p_skip_long)
		else $error("skip over two words not three cycles");

	property p_cmp_noskip;
		accept && issueOp == OP_CMP_SKIP_EQUAL && operandA != operandB
			|=> cycles == 5'h01 && flagMask == '0 ##1 done;
	endproperty
	a_cmp_noskip: assert property (p_cmp_noskip)
		else $error("compare without skip not one cycle");

	property p_divide;
		accept && issueOp == OP_DIVIDE |-> ##2 !done ##16 !done ##1 done;
	endproperty
	a_divide: assert property (p_divide)
		else $error("divide not eighteen cycles");

	property p_holdoff;
		accept && issueOp == OP_HOLDOFF && opLiteral == 14'h0002 |=>
			intHoldoff ##1 intHoldoff ##1 !intHoldoff;
	endproperty
	a_holdoff: assert property (p_holdoff)
		else $error("holdoff length wrong");

	property p_loop_count;
		accept && issueOp == OP_HW_LOOP |=>
			iterLoad && words == 2'h2 &&
			iterCount == {1'b0, $past(opLiteral)} + 15'h0001;
	endproperty
	a_loop_count: assert property (p_loop_count)
		else $error("loop count or words wrong");

	property p_pop_shadow;
		accept && issueOp == OP_POP_SHADOW |=> flagMask == 13'h07ff;
	endproperty
	a_pop_shadow: assert property (p_pop_shadow)
		else $error("shadow pop flags wrong");

	property p_sleep;
		accept && issueOp == OP_POWER_SAVE |=>
			sleepReq == !$past(opLiteral[0]) && idleReq != sleepReq;
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("power save mode choice wrong");

	property p_return;
		accept && issueOp == OP_RETURN && !retShort |=> ##1 s_three_cycle;
	endproperty
	a_return: assert property (p_return)
		else $error("return not three cycles");

endmodule

// [tb_top.sv]
module tb_top
	import dtf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic              clk = 1'b0;
	logic              rst_n = 1'b0;
	logic              issueValid = 1'b0;
	dtf_op_e           issueOp = OP_NOP;
	logic              condTrue = 1'b0;
	logic              nextTwoWord = 1'b0;
	logic              retShort = 1'b0;
	logic [15:0]       operandA = 16'h0000;
	logic [15:0]       operandB = 16'h0000;
	logic [LIT_W-1:0]  opLiteral = 14'h0000;
	logic              ready;
	logic              done;
	logic [4:0]        cycles;
	logic [1:0]        words;
	logic [FLAG_W-1:0] flagMask;
	logic              accAccumulate;
	logic              accNegate;
	logic [LIT_W:0]    iterCount;
	logic              iterLoad;
	logic              sleepReq;
	logic              idleReq;
	logic              intHoldoff;
	int                err_total = 0;
	int                compares = 0;

	always #10 clk = ~clk;

	dtf_timing_flags i_dut (
		.clk, .rst_n, .issueValid, .issueOp, .condTrue, .nextTwoWord,
		.retShort, .operandA, .operandB, .opLiteral, .ready, .done,
		.cycles, .words, .flagMask, .accAccumulate, .accNegate,
		.iterCount, .iterLoad, .sleepReq, .idleReq, .intHoldoff
	);

	////////////////////////////////////////
	// shared helpers
	task automatic chk(input string nm, input logic [15:0] seen,
			input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	function automatic logic [4:0] skipCyc(input logic skip, input logic tw);
		return skip ? (tw ? CYC_THREE : CYC_TWO) : CYC_ONE;
	endfunction

	task automatic issue(input dtf_op_e op, input logic c, input logic tw,
			input logic rs, input logic [LIT_W-1:0] lit);
		@(posedge clk);
		issueValid <= 1'b1;
		issueOp <= op;
		condTrue <= c;
		nextTwoWord <= tw;
		retShort <= rs;
		opLiteral <= lit;
		@(posedge clk);
		issueValid <= 1'b0;
	endtask

	task automatic waitDone(inout int n);
		while (done !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		if (n >= 40) begin
			err_total++;
			finish_test();
		end
	endtask

	task automatic run(input dtf_op_e op, input logic [4:0] ec,
			input logic [FLAG_W-1:0] em, input logic c = 1'b0,
			input logic tw = 1'b0, input logic rs = 1'b0,
			input logic [LIT_W-1:0] lit = 14'h0000,
			input logic [1:0] ew = WORDS_ONE);
		int n;
		issue(op, c, tw, rs, lit);
		@(negedge clk);
		chk("ready", ready, 16'(ec == CYC_ONE));
		n = 0;
		waitDone(n);
		chk("latency", 16'(n), ec);
		chk("cycles", cycles, ec);
		chk("words", words, ew);
		chk("flagMask", flagMask, em);
	endtask

	task automatic pulses(input dtf_op_e op, input logic [LIT_W-1:0] lit,
			input logic [2:0] e);
		int nI;
		int nS;
		int nD;
		nI = 0;
		nS = 0;
		nD = 0;
		issue(op, 1'b0, 1'b0, 1'b0, lit);
		for (int i = 0; i < 4; i++) begin
			@(negedge clk);
			nI += (iterLoad === 1'b1);
			nS += (sleepReq === 1'b1);
			nD += (idleReq === 1'b1);
		end
		chk("iterLoad", 16'(nI), 16'(e[0]));
		chk("sleepReq", 16'(nS), 16'(e[1]));
		chk("idleReq", 16'(nD), 16'(e[2]));
	endtask

	////////////////////////////////////////
	// scenarios
	task automatic t_burst();
		dtf_op_e           bo[3] = '{OP_ASR_ONE, OP_ASR_MULTI, OP_FIND_BIT};
		logic [FLAG_W-1:0] bm[3] = '{13'h001d, 13'h0014, 13'h0001};
		@(posedge clk);
		issueValid <= 1'b1;
		issueOp <= bo[0];
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			if (i < 2) begin
				issueOp <= bo[i + 1];
			end else begin
				issueValid <= 1'b0;
			end
			@(negedge clk);
			chk("done", done, 16'(i > 0));
			chk("flagMask", flagMask, bm[i]);
		end
		@(negedge clk);
		chk("done", done, 16'h0001);
	endtask

	task automatic t_skips();
		logic signed [15:0] pa[2] = '{16'sh8000, 16'sh0005};
		logic signed [15:0] pb[2] = '{16'sh0001, 16'sh0005};
		logic               tw;
		for (int i = 0; i < 4; i++) begin
			run(OP_BIT_SKIP_CLEAR, skipCyc(!i[0], i[1]), 13'h0000,
				i[0], i[1]);
			run(OP_BIT_SKIP_SET, skipCyc(i[0], i[1]), 13'h0000,
				i[0], i[1]);
		end
		for (int p = 0; p < 2; p++) begin
			tw = p[0];
			@(posedge clk);
			operandA <= pa[p];
			operandB <= pb[p];
			run(OP_CMP_SKIP_EQUAL, skipCyc(pa[p] == pb[p], tw),
				13'h0000, 1'b0, tw);
			run(OP_CMP_SKIP_GREATER, skipCyc(pa[p] > pb[p], tw),
				13'h0000, 1'b0, tw);
			run(OP_CMP_SKIP_LESS, skipCyc(pa[p] < pb[p], tw),
				13'h0000, 1'b0, tw);
			run(OP_CMP_SKIP_UNEQUAL, skipCyc(pa[p] != pb[p], tw),
				13'h0000, 1'b0, tw);
		end
	endtask

	task automatic t_holdoff(input logic [LIT_W-1:0] k);
		logic [15:0] seen;
		seen = 16'h0000;
		issue(OP_HOLDOFF, 1'b0, 1'b0, 1'b0, k);
		for (int i = 1; i < 9; i++) begin
			@(negedge clk);
			seen[i] = intHoldoff;
		end
		chk("intHoldoff", seen, (16'h0001 << (k + 1)) - 16'h0002);
		chk("cycles", cycles, CYC_ONE);
		chk("flagMask", flagMask, 13'h0000);
	endtask

	task automatic t_divide();
		int n;
		@(posedge clk);
		issueValid <= 1'b1;
		issueOp <= OP_DIVIDE;
		@(posedge clk);
		issueOp <= OP_WATCHDOG_CLEAR;
		repeat (5) @(posedge clk);
		issueValid <= 1'b0;
		@(negedge clk);
		n = 5;
		waitDone(n);
		chk("latency", 16'(n), CYC_DIVIDE);
		chk("flagMask", flagMask, 13'h001d);
		run(OP_FRAC_DIVIDE, CYC_DIVIDE, 13'h001d);
	endtask

	task automatic t_misc();
		run(OP_BRANCH_COND, CYC_ONE, 13'h0000, 1'b0);
		run(OP_BRANCH_COND, CYC_TWO, 13'h0000, 1'b1);
		run(OP_TEST_SET_C, CYC_ONE, 13'h0001);
		run(OP_TEST_SET_Z, CYC_ONE, 13'h0010);
		run(OP_HW_LOOP, CYC_TWO, 13'h0000, 1'b0, 1'b0, 1'b0, 14'h0000,
			WORDS_TWO);
		chk("iterCount", iterCount, 16'h0001);
		pulses(OP_REPEAT, 14'h3fff, 3'b001);
		chk("iterCount", iterCount, 16'h4000);
		chk("cycles", cycles, CYC_ONE);
		run(OP_SQ_DIST, CYC_ONE, 13'h07e0);
		chk("accAccumulate", accAccumulate, 16'h0000);
		run(OP_SQ_DIST_ACC, CYC_ONE, 13'h07e0);
		chk("accAccumulate", accAccumulate, 16'h0001);
		run(OP_MULT_ACC, CYC_ONE, 13'h07e0);
		run(OP_NEG_MULT_ACC, CYC_ONE, 13'h0000);
		chk("accNegate", accNegate, 16'h0001);
		run(OP_DOUBLE_MOVE, CYC_TWO, 13'h0000);
		run(OP_MOVE_NZ, CYC_ONE, 13'h0014);
		run(OP_MOVE_PLAIN, CYC_ONE, 13'h0000);
		run(OP_INT_MULTIPLY, CYC_ONE, 13'h0000);
		run(OP_DOUBLE_STACK, CYC_TWO, 13'h0000);
		run(OP_PUSH_SHADOW, CYC_ONE, 13'h0000);
		run(OP_POP_SHADOW, CYC_ONE, FLAGS_ALL);
		pulses(OP_POWER_SAVE, 14'h0000, 3'b010);
		chk("flagMask", flagMask, 13'h1800);
		pulses(OP_POWER_SAVE, 14'h0001, 3'b100);
		run(OP_WATCHDOG_CLEAR, CYC_ONE, 13'h1800);
		run(OP_RETURN, CYC_THREE, 13'h0000);
		run(OP_RETURN, CYC_TWO, 13'h0000, 1'b0, 1'b0, 1'b1);
		run(OP_DECIMAL_ADJUST, CYC_ONE, 13'h0001);
		run(OP_CMP_BORROW, CYC_ONE, 13'h001f);
	endtask

	task automatic t_midreset();
		issue(OP_DIVIDE, 1'b0, 1'b0, 1'b0, 14'h0000);
		repeat (3) @(posedge clk);
		rst_n <= 1'b0;
		@(negedge clk);
		chk("ready", ready, 16'h0001);
		chk("cycles", cycles, 16'h0000);
		chk("flagMask", flagMask, 16'h0000);
		@(posedge clk);
		rst_n <= 1'b1;
		run(OP_NOP, CYC_ONE, 13'h0000);
	endtask

	////////////////////////////////////////
	// main sequence
	initial begin
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk("ready", ready, 16'h0001);
		chk("done", done, 16'h0000);
		chk("iterCount", iterCount, 16'h0000);
		chk("intHoldoff", intHoldoff, 16'h0000);
		@(posedge clk);
		rst_n <= 1'b1;
		t_burst();
		t_skips();
		t_holdoff(14'h0000);
		t_holdoff(14'h0001);
		t_holdoff(14'h0007);
		t_divide();
		t_misc();
		t_midreset();
		finish_test();
	end
endmodule
